/* rtl/hp_host_port.sv */
// host port status flags and receive bus mapping of the link transceiver
`timescale 1ns/1ps
module hp_host_port #(
  parameter logic [7:0][2:0] SPECIAL_MAP = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}
) (
  input  wire logic              sys_clk,               // transmit side clock, 40 MHz
  input  wire logic              srst,                  // synchronous reset, active high
  input  wire logic              rx_interface_clock,    // receive interface clock from host
  // configuration pins
  input  wire logic              fifo_bypass_n,         // low bypasses both fifos
  input  wire logic              codec_bypass_n,        // low bypasses encoder and decoder
  input  wire logic              width_select,          // high 8-bit, low 10-bit characters
  input  wire logic              cascade_timing_select, // high cascade, low utopia timing
  input  wire logic              address_match_n,       // low while device is addressed
  input  wire logic [1:0]        rx_discard_policy,     // receive discard policy
  // transmit pins
  input  wire logic              tx_selftest_enable_n,  // low runs transmit self-test
  input  wire logic              tx_fifo_reset_n,       // low requests transmit fifo reset
  output logic                   tx_empty_flag_o,       // empty / ready / progress flag
  output logic                   tx_empty_flag_oe,      // flag driven while addressed
  // transmit core side
  input  wire logic              tx_fifo_is_empty,      // transmit fifo holds nothing
  input  wire logic              tx_accept_ready,       // bypass path can take a character
  input  wire logic              tx_char_strobe,        // one character left the encoder
  output logic                   tx_fifo_reset_start,   // pulse: begin fifo reset
  output logic                   tx_fifo_read_suspend,  // hold off fifo reads
  output logic                   tx_selftest_active,    // send self-test pattern
  output logic [8:0]             tx_selftest_pos,       // character index in the pattern
  // receive pins
  input  wire logic              rx_bus_enable,         // receive enable, polarity by timing mode
  output logic [11:0]            rx_parallel_bus_o,     // receive bus incl. shared bits
  output logic                   rx_parallel_bus_oe,    // receive bus driven
  output logic                   rx_special_flag_o,     // special / data indicator
  output logic                   rx_special_flag_oe,    // indicator driven
  // receive core side
  input  wire logic              rx_dec_valid,          // decoder has a character
  input  hp_pkg::hp_rx_char_t    rx_dec_char,           // character ahead of the fifo
  output logic                   rx_fifo_store,         // pulse: write character to fifo
  output hp_pkg::hp_rx_char_t    rx_fifo_store_data,    // character to write
  input  hp_pkg::hp_rx_char_t    rx_fifo_rd_data,       // word at the fifo head
  output logic                   rx_fifo_read           // pulse: fifo head taken
);

  // ---------------- transmit side, sys_clk ----------------

  typedef struct packed {
    logic       empty_flag;
    logic       empty_oe;
    logic [3:0] rst_cnt;
    logic       rst_start;
    logic       suspend;
    logic [8:0] st_pos;
    logic       st_active;
  } hp_tx_state_t;

  hp_tx_state_t tx_q;
  hp_tx_state_t tx_d;

  logic       tx_byp_n_s;
  logic       tx_cascade_s;
  logic       tx_am_n_s;
  logic       tx_st_n_s;
  logic       tx_rst_n_s;
  logic       st_active;
  logic       st_seq_end;
  logic [8:0] st_pos;
  logic       tx_flag_act;

  // pin levels into the transmit clock domain
  hp_sync #(.W(5)) u_tx_sync (
    .clk     (sys_clk),
    .rst     (srst),
    .rst_val (5'h1F),
    .d       ({fifo_bypass_n, cascade_timing_select, address_match_n,
               tx_selftest_enable_n, tx_fifo_reset_n}),
    .q       ({tx_byp_n_s, tx_cascade_s, tx_am_n_s, tx_st_n_s, tx_rst_n_s})
  );

  assign st_active = !tx_st_n_s;

  // self-test sequence position and end marker
  hp_selftest_seq u_seq (
    .clk         (sys_clk),
    .rst         (srst),
    .active      (st_active),
    .char_strobe (tx_char_strobe),
    .pos         (st_pos),
    .seq_end     (st_seq_end)
  );

  // choose the flag meaning before polarity is applied
  always_comb
  begin
    if (st_active)
    begin
      tx_flag_act = st_seq_end;
    end
    else if (!tx_byp_n_s)
    begin
      tx_flag_act = tx_accept_ready;
    end
    else
    begin
      tx_flag_act = tx_fifo_is_empty;
    end
  end

  // flag polarity, reset hold counter and read suspend
  always_comb
  begin
    tx_d            = tx_q;
    tx_d.empty_flag = tx_cascade_s ? tx_flag_act : !tx_flag_act;
    tx_d.empty_oe   = !tx_am_n_s;
    tx_d.suspend    = st_active;
    tx_d.st_active  = st_active;
    tx_d.st_pos     = st_pos;                 // position handed to the serializer
    tx_d.rst_start  = 1'b0;
    if (!tx_byp_n_s || tx_rst_n_s)
    begin
      tx_d.rst_cnt = hp_pkg::TX_RST_CNT_RST;
    end
    else if (tx_q.rst_cnt != hp_pkg::TX_RST_HOLD)
    begin
      tx_d.rst_cnt = tx_q.rst_cnt + 4'h1;
      // eighth consecutive low sample starts the reset once
      if (tx_q.rst_cnt == (hp_pkg::TX_RST_HOLD - 4'h1))
      begin
        tx_d.rst_start = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tx_q <= '{empty_flag: 1'b0, empty_oe: 1'b0, rst_cnt: hp_pkg::TX_RST_CNT_RST,
                rst_start: 1'b0, suspend: 1'b0, st_pos: hp_pkg::SELFTEST_POS_RST, st_active: 1'b0};
    end
    else
    begin
      tx_q <= tx_d;
    end
  end

  assign tx_empty_flag_o      = tx_q.empty_flag;
  assign tx_empty_flag_oe     = tx_q.empty_oe;
  assign tx_fifo_reset_start  = tx_q.rst_start;
  assign tx_fifo_read_suspend = tx_q.suspend;
  assign tx_selftest_active   = tx_q.st_active;
  assign tx_selftest_pos      = tx_q.st_pos;

  // ---------------- receive side, rx_interface_clock ----------------

  typedef struct packed {
    hp_pkg::hp_rx_pins_t pins;
    logic                oe;
    logic                ind_oe;
    logic                irq;
    logic                store;
    hp_pkg::hp_rx_char_t store_data;
    logic                rd;
  } hp_rx_state_t;

  hp_rx_state_t rx_q;
  hp_rx_state_t rx_d;

  logic       rx_rst;
  logic       rx_byp_n_s;
  logic       rx_codec_n_s;
  logic       rx_w8_s;
  logic       rx_cascade_s;
  logic       rx_am_n_s;
  logic       rx_en_s;
  logic [1:0] rx_pol_s;
  logic       rx_sel;
  logic       rx_fifo_mode;

  // reset carried into the receive domain
  hp_sync #(.W(1)) u_rx_rst (
    .clk     (rx_interface_clock),
    .rst     (1'b0),
    .rst_val (1'b1),
    .d       (srst),
    .q       (rx_rst)
  );

  // pin levels into the receive clock domain
  hp_sync #(.W(8)) u_rx_sync (
    .clk     (rx_interface_clock),
    .rst     (rx_rst),
    .rst_val (8'h3C),
    .d       ({fifo_bypass_n, codec_bypass_n, width_select, cascade_timing_select,
               address_match_n, rx_bus_enable, rx_discard_policy}),
    .q       ({rx_byp_n_s, rx_codec_n_s, rx_w8_s, rx_cascade_s,
               rx_am_n_s, rx_en_s, rx_pol_s})
  );

  // fifo and decoder both in use
  assign rx_fifo_mode = rx_byp_n_s && rx_codec_n_s;

  // enable polarity follows the timing mode
  assign rx_sel = !rx_am_n_s && (rx_cascade_s ? rx_en_s : !rx_en_s);

  // true for the two command codes that steer the remote interrupt
  function automatic logic is_irq_code(input hp_pkg::hp_rx_char_t c);
    is_irq_code = c.special && ((c.dec[7:0] == hp_pkg::CODE_IRQ_SET) ||
                                (c.dec[7:0] == hp_pkg::CODE_IRQ_CLR));
  endfunction

  // map one character onto the receive pins
  function automatic hp_pkg::hp_rx_pins_t map_pins(
    input hp_pkg::hp_rx_char_t c,
    input logic                fifo_on,
    input logic                codec_on,
    input logic                w8,
    input logic                irq
  );
    hp_pkg::hp_rx_pins_t p;
    logic [2:0]          ind;
    p   = '0;
    ind = c.special ? SPECIAL_MAP[c.dec[7:5]] : {1'b0, 1'b0, c.cell_start};
    if (!codec_on)
    begin
      p.bus[7:0]                 = c.raw[7:0];
      p.bus[hp_pkg::RX_BIT_IRQ]   = c.raw[8];
      p.bus[hp_pkg::RX_BIT_MSB10] = c.raw[9];
      p.bus[hp_pkg::RX_BIT_VIOL]  = w8 ? 1'b0 : c.raw[10];
      p.bus[hp_pkg::RX_BIT_SOC]   = w8 ? 1'b0 : c.raw[11];
    end
    else
    begin
      p.bus[7:0]                 = c.dec[7:0];
      p.bus[hp_pkg::RX_BIT_MSB10] = w8 ? 1'b0 : c.dec[9];
      if (fifo_on)
      begin
        p.bus[hp_pkg::RX_BIT_IRQ]  = irq;
        p.bus[hp_pkg::RX_BIT_VIOL] = ind[2];
        p.special_flag             = ind[1];
        p.bus[hp_pkg::RX_BIT_SOC]  = ind[0];
      end
      else
      begin
        p.bus[hp_pkg::RX_BIT_IRQ]  = 1'b0;
        p.bus[hp_pkg::RX_BIT_VIOL] = c.violation;
        p.special_flag             = c.special;
      end
    end
    map_pins = p;
  endfunction

  // interrupt tracking, fifo write filter and bus output register
  always_comb
  begin
    rx_d            = rx_q;
    rx_d.store      = 1'b0;
    rx_d.rd         = 1'b0;
    rx_d.store_data = rx_dec_char;
    if (rx_fifo_mode && rx_dec_valid && rx_dec_char.special)
    begin
      if (rx_dec_char.dec[7:0] == hp_pkg::CODE_IRQ_SET)
      begin
        rx_d.irq = 1'b1;
      end
      else if (rx_dec_char.dec[7:0] == hp_pkg::CODE_IRQ_CLR)
      begin
        rx_d.irq = 1'b0;
      end
    end
    if (rx_byp_n_s && rx_dec_valid)
    begin
      rx_d.store = !(rx_fifo_mode && is_irq_code(rx_dec_char) &&
                     (rx_pol_s != hp_pkg::DISCARD_KEEP_ALL));
    end
    rx_d.oe = rx_sel;
    rx_d.ind_oe = rx_sel && rx_codec_n_s;                      // indicator only with decoder in use
    if (rx_sel)
    begin
      rx_d.rd   = rx_byp_n_s;
      rx_d.pins = map_pins(rx_byp_n_s ? rx_fifo_rd_data : rx_dec_char,
                           rx_byp_n_s, rx_codec_n_s, rx_w8_s, rx_d.irq);
    end
  end

  always_ff @(posedge rx_interface_clock)
  begin
    if (rx_rst)
    begin
      rx_q <= '{pins: '{bus: hp_pkg::RX_BUS_RST, special_flag: 1'b0}, oe: 1'b0, ind_oe: 1'b0,
                irq: hp_pkg::IRQ_RST, store: 1'b0, store_data: '0, rd: 1'b0};
    end
    else
    begin
      rx_q <= rx_d;
    end
  end

  assign rx_parallel_bus_o  = rx_q.pins.bus;
  assign rx_parallel_bus_oe = rx_q.oe;
  assign rx_special_flag_o  = rx_q.pins.special_flag;
  assign rx_special_flag_oe = rx_q.ind_oe;
  assign rx_fifo_store      = rx_q.store;
  assign rx_fifo_store_data = rx_q.store_data;
  assign rx_fifo_read       = rx_q.rd;

endmodule

/* include/hp_pkg.sv */
// shared constants and carrier types for the host port status and receive mapping block
package hp_pkg;

  // transmit self-test sequence length in characters
  localparam int unsigned SELFTEST_LEN      = 511;
  localparam logic [8:0]  SELFTEST_LAST     = 9'h1_FE;
  localparam logic [8:0]  SELFTEST_POS_RST  = 9'h0_00;

  // consecutive sampled cycles the fifo reset input must be held low
  localparam logic [3:0]  TX_RST_HOLD       = 4'h8;
  localparam logic [3:0]  TX_RST_CNT_RST    = 4'h0;

  // decoded special codes that steer the remote interrupt output
  localparam logic [7:0]  CODE_IRQ_SET      = 8'h1C;  // K28.0
  localparam logic [7:0]  CODE_IRQ_CLR      = 8'h7C;  // K28.3
  localparam logic [1:0]  DISCARD_KEEP_ALL  = 2'h0;

  // receive bus bit positions of shared pins
  localparam int unsigned RX_BIT_IRQ        = 8;
  localparam int unsigned RX_BIT_MSB10      = 9;
  localparam int unsigned RX_BIT_VIOL       = 10;
  localparam int unsigned RX_BIT_SOC        = 11;

  // reset values
  localparam logic        IRQ_RST           = 1'b0;
  localparam logic [11:0] RX_BUS_RST        = 12'h0_00;

  // one received character, as seen before and after the receive fifo
  typedef struct packed {
    logic [11:0] raw;          // undecoded 10 or 12 bit character
    logic [9:0]  dec;          // decoded character
    logic        special;      // decoded character is a special code
    logic        violation;    // invalid code word seen
    logic        cell_start;   // start of cell marker
  } hp_rx_char_t;

  // pin image of the receive side outputs
  typedef struct packed {
    logic [11:0] bus;          // receive parallel bus incl. shared bits
    logic        special_flag; // special character / data indicator
  } hp_rx_pins_t;

endpackage

/* rtl/hp_sync.sv */
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module hp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,   // destination clock
  input  wire logic         rst,   // synchronous reset, active high
  input  wire logic [W-1:0] rst_val, // value taken under reset
  input  wire logic [W-1:0] d,     // asynchronous input
  output logic      [W-1:0] q      // synchronised output
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= rst_val;
      q      <= rst_val;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* rtl/hp_selftest_seq.sv */
// transmit self-test sequence position counter
`timescale 1ns/1ps
module hp_selftest_seq (
  input  wire logic       clk,         // transmit side clock
  input  wire logic       rst,         // synchronous reset, active high
  input  wire logic       active,      // self-test enabled
  input  wire logic       char_strobe, // one character sent
  output logic      [8:0] pos,         // position in the sequence
  output logic            seq_end      // one-cycle pulse after last character
);

  typedef struct packed {
    logic [8:0] pos;
    logic       seq_end;
  } hp_seq_state_t;

  hp_seq_state_t s_q;
  hp_seq_state_t s_d;

  // walk 511 characters and wrap, flag the wrap for one cycle
  always_comb
  begin
    s_d         = s_q;
    s_d.seq_end = 1'b0;
    if (!active)
    begin
      s_d.pos = hp_pkg::SELFTEST_POS_RST;
    end
    else if (char_strobe)
    begin
      if (s_q.pos == hp_pkg::SELFTEST_LAST)
      begin
        s_d.pos     = hp_pkg::SELFTEST_POS_RST;
        s_d.seq_end = 1'b1;
      end
      else
      begin
        s_d.pos = s_q.pos + 9'h0_01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '{pos: hp_pkg::SELFTEST_POS_RST, seq_end: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pos     = s_q.pos;
  assign seq_end = s_q.seq_end;

endmodule

/* tb/hp_assertions.sv */
// assertions on the host port status flags and receive bus
`timescale 1ns/1ps
module hp_assertions (
  input wire logic sys_clk,               // tx clock
  input wire logic srst,                  // reset
  input wire logic rx_interface_clock,    // rx clock
  input wire logic fifo_bypass_n,         // bypass pin
  input wire logic cascade_timing_select, // polarity pin
  input wire logic address_match_n,       // address pin
  input wire logic tx_selftest_enable_n,  // self-test pin
  input wire logic tx_fifo_reset_n,       // reset pin
  input wire logic tx_empty_flag_o,       // empty flag
  input wire logic tx_fifo_reset_start,   // reset pulse
  input wire logic tx_fifo_read_suspend,  // read hold-off
  input wire logic tx_selftest_active,    // self-test on
  input wire logic rx_parallel_bus_oe,    // bus driven
  input wire logic rx_fifo_read           // head taken
);
  logic [3:0] low_q;  // low samples of the reset pin
  logic [2:0] rrst_q; // reset seen by the receive side
  // saturating count of the reset pin held low
  always_ff @(posedge sys_clk) low_q <= tx_fifo_reset_n ? 4'h0 : low_q + {3'h0, low_q != 4'hF};
  // reset stretched over the receive synchroniser
  always_ff @(posedge rx_interface_clock) rrst_q <= {rrst_q[1:0], srst};
  // host deselected for three receive edges
  sequence seq_desel;
    address_match_n [*3];
  endsequence
  AST_RST_ONE: assert property (@(posedge sys_clk) disable iff (srst)
    tx_fifo_reset_start |=> !tx_fifo_reset_start) else $error("reset pulse too long");
  AST_RST_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
    tx_fifo_reset_start |-> $past(low_q, 2) >= 4'h8) else $error("reset pulse after short hold");
  AST_RST_BYP: assert property (@(posedge sys_clk) disable iff (srst)
    tx_fifo_reset_start |-> $past(fifo_bypass_n, 3)) else $error("reset pulse while bypassed");
  AST_SUSPEND: assert property (@(posedge sys_clk) disable iff (srst)
    tx_fifo_read_suspend == !$past(tx_selftest_enable_n, 3) && tx_selftest_active == tx_fifo_read_suspend)
    else $error("read suspend differs from self-test");
  AST_TEST_ON: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(tx_selftest_enable_n) |-> ##[2:4] tx_selftest_active) else $error("self-test did not start");
  AST_PULSE: assert property (@(posedge sys_clk) disable iff (srst)
    $past(tx_selftest_active) && tx_selftest_active && cascade_timing_select && tx_empty_flag_o
    |=> !tx_empty_flag_o || !tx_selftest_active) else $error("progress pulse too long");
  AST_DESEL_OE: assert property (@(posedge rx_interface_clock) disable iff (srst || rrst_q != 3'h0)
    seq_desel |=> !rx_parallel_bus_oe) else $error("bus driven while deselected");
  AST_DESEL_RD: assert property (@(posedge rx_interface_clock) disable iff (srst || rrst_q != 3'h0)
    seq_desel |=> !rx_fifo_read) else $error("fifo read while deselected");
  AST_RD_SHOWN: assert property (@(posedge rx_interface_clock) disable iff (srst || rrst_q != 3'h0)
    rx_fifo_read |-> rx_parallel_bus_oe) else $error("fifo read with bus undriven");
endmodule

bind hp_host_port hp_assertions i_hp_assertions (.sys_clk, .srst, .rx_interface_clock, .fifo_bypass_n,
  .cascade_timing_select, .address_match_n, .tx_selftest_enable_n, .tx_fifo_reset_n, .tx_empty_flag_o,
  .tx_fifo_reset_start, .tx_fifo_read_suspend, .tx_selftest_active, .rx_parallel_bus_oe, .rx_fifo_read);

/* tb/hp_core_model.sv */
// core side model: character strobes and receive fifo head
`timescale 1ns/1ps
module hp_core_model (
  input  wire logic           sys_clk,            // tx clock
  input  wire logic           rx_interface_clock, // rx clock
  input  wire logic           rx_fifo_read,       // head taken
  input  hp_pkg::hp_rx_char_t next_word,          // word behind head
  output logic                tx_char_strobe,     // character sent
  output hp_pkg::hp_rx_char_t rx_fifo_rd_data,    // fifo head
  output int                  n_read              // words taken
);
  // one character leaves the encoder every second clock
  initial tx_char_strobe = 1'h0;
  always @(posedge sys_clk) tx_char_strobe <= ~tx_char_strobe;
  // each read moves the queued word to the head, one word per edge
  initial
  begin
    rx_fifo_rd_data = '0;
    n_read = 0;
  end
  always @(posedge rx_interface_clock)
    if (rx_fifo_read === 1'h1)
    begin
      rx_fifo_rd_data <= next_word;
      n_read <= n_read + 1;
    end
endmodule

/* tb/tb_hp_host_port.sv */
// self-checking bench for the host port flags and receive mapping
`timescale 1ns/1ps
module tb_hp_host_port;
  logic sys_clk = 1'h0, srst = 1'h1, rx_interface_clock = 1'h0, fifo_bypass_n = 1'h1, codec_bypass_n = 1'h1;
  logic width_select = 1'h0, cascade_timing_select = 1'h1, address_match_n = 1'h1, tx_selftest_enable_n = 1'h1;
  logic tx_fifo_reset_n = 1'h1, tx_fifo_is_empty = 1'h0, tx_accept_ready = 1'h0, rx_bus_enable = 1'h0;
  logic rx_dec_valid = 1'h0;
  logic [1:0] rx_discard_policy = 2'h1;
  logic tx_empty_flag_o, tx_empty_flag_oe, tx_fifo_reset_start, tx_fifo_read_suspend, tx_selftest_active;
  logic tx_char_strobe, rx_parallel_bus_oe, rx_special_flag_o, rx_fifo_store, rx_fifo_read;
  logic [11:0] rx_parallel_bus_o;
  logic [8:0] tx_selftest_pos;
  logic rx_special_flag_oe;
  hp_pkg::hp_rx_char_t rx_dec_char = '0, next_word = '0, rx_fifo_rd_data, rx_fifo_store_data, st_word = '0;
  int n_mismatch = 0, num_checks = 0, n_rst = 0, n_flag = 0, n_store = 0, n_read, r0;

  hp_host_port i_hp_host_port (.sys_clk, .srst, .rx_interface_clock, .fifo_bypass_n, .codec_bypass_n,
    .width_select, .cascade_timing_select, .address_match_n, .rx_discard_policy, .tx_selftest_enable_n,
    .tx_fifo_reset_n, .tx_empty_flag_o, .tx_empty_flag_oe, .tx_fifo_is_empty, .tx_accept_ready, .tx_char_strobe,
    .tx_fifo_reset_start, .tx_fifo_read_suspend, .tx_selftest_active, .tx_selftest_pos, .rx_bus_enable,
    .rx_parallel_bus_o, .rx_parallel_bus_oe, .rx_special_flag_o, .rx_special_flag_oe, .rx_dec_valid,
    .rx_dec_char, .rx_fifo_store, .rx_fifo_store_data, .rx_fifo_rd_data, .rx_fifo_read);
  hp_core_model i_hp_core_model (.sys_clk, .rx_interface_clock, .rx_fifo_read, .next_word, .tx_char_strobe,
    .rx_fifo_rd_data, .n_read);

  // 40 MHz transmit clock and an unrelated 8 MHz receive clock
  initial forever #12.5 sys_clk = ~sys_clk;
  initial
  begin
    #7;
    forever #62.5 rx_interface_clock = ~rx_interface_clock;
  end
  // event counters on the design outputs
  always @(posedge sys_clk)
  begin
    if (tx_fifo_reset_start === 1'h1) n_rst++;
    if (tx_selftest_active === 1'h1 && tx_empty_flag_o === 1'h1) n_flag++;
  end
  always @(posedge rx_interface_clock)
    if (rx_fifo_store === 1'h1)
    begin
      n_store++;
      st_word = rx_fifo_store_data;
    end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rk(input int n);
    repeat (n) @(negedge rx_interface_clock);
  endtask
  // fifo reset pin low for n sampled edges
  task automatic hold(input int n);
    tx_fifo_reset_n = 1'h0;
    tk(n);
    tx_fifo_reset_n = 1'h1;
    tk(8);
  endtask
  // one decoded character ahead of the receive fifo
  task automatic send(input logic [9:0] dec, input logic spec);
    rx_dec_char = {12'h000, dec, spec, 1'h0, 1'h0};
    rx_dec_valid = 1'h1;
    rk(1);
    rx_dec_valid = 1'h0;
    rk(5);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #300000;
    n_mismatch++;
    end_sim;
  end

  initial
  begin
    tk(20);
    srst = 1'h0;
    tk(4);
    address_match_n = 1'h0;
    // flag source and polarity; ready and empty inputs always disagree
    for (int i = 0; i < 8; i++)
    begin
      fifo_bypass_n = i[2];
      cascade_timing_select = i[1];
      tx_accept_ready = i[0];
      tx_fifo_is_empty = ~i[0];
      tk(5);
      chk("empty_flag", {11'h000, ~(i[0] ^ i[1] ^ i[2])}, {11'h000, tx_empty_flag_o});
    end
    chk("flag_oe", 12'h001, {11'h000, tx_empty_flag_oe});
    $display("test tx_flag done");
    // fifo reset: short hold, exact hold, long hold, then bypassed
    hold(7);
    chk("rst_short", 12'h000, 12'(n_rst));
    hold(8);
    chk("rst_eight", 12'h001, 12'(n_rst));
    hold(20);
    chk("rst_long", 12'h002, 12'(n_rst));
    fifo_bypass_n = 1'h0;
    tk(4);
    hold(20);
    chk("rst_bypassed", 12'h002, 12'(n_rst));
    $display("test tx_reset done");
    // self-test while bypassed with the ready input high
    cascade_timing_select = 1'h1;
    tx_accept_ready = 1'h1;
    tx_selftest_enable_n = 1'h0;
    for (int i = 0; i < 10 && tx_selftest_active !== 1'h1; i++) tk(1);
    if (tx_selftest_active !== 1'h1)
    begin
      n_mismatch++;
      end_sim;
    end
    chk("suspend", 12'h001, {11'h000, tx_fifo_read_suspend});
    n_flag = 0;
    r0 = tx_selftest_pos;
    tk(20);
    chk("pos_step", 12'h00A, 12'(tx_selftest_pos - r0));
    tk(2044);
    chk("progress_pulses", 12'h002, 12'(n_flag));
    tx_selftest_enable_n = 1'h1;
    tk(6);
    chk("after_test", 12'h001, {1'h0, tx_selftest_pos, tx_selftest_active, tx_empty_flag_o});
    $display("test tx_selftest done");
    // receive: decoder bypassed, fifo head holds a raw character
    rk(1);
    fifo_bypass_n = 1'h1;
    codec_bypass_n = 1'h0;
    next_word = {12'hD6B, 10'h2C5, 1'h0, 1'h0, 1'h1};
    rx_bus_enable = 1'h1;
    rk(6);
    chk("bus_raw10", 12'hD6B, rx_parallel_bus_o);
    chk("sf_oe_raw", 12'h000, {11'h000, rx_special_flag_oe});
    width_select = 1'h1;
    rk(6);
    chk("bus_raw8", 12'h16B, rx_parallel_bus_o);
    r0 = n_read;
    rk(5);
    chk("reads_per_edge", 12'h005, 12'(n_read - r0));
    address_match_n = 1'h1;
    rk(4);
    r0 = n_read;
    rk(4);
    chk("reads_deselected", 12'h000, 12'(n_read - r0));
    chk("oe_deselected", 12'h000, {11'h000, rx_parallel_bus_oe});
    $display("test rx_raw done");
    // decoded fifo mode: data word, special word, interrupt codes
    codec_bypass_n = 1'h1;
    width_select = 1'h0;
    address_match_n = 1'h0;
    rk(6);
    chk("bus_dec10", 12'h2C5, {2'h0, rx_parallel_bus_o[9], 1'h0, rx_parallel_bus_o[7:0]});
    chk("ind_data", 12'h009, {8'h00, rx_special_flag_oe, rx_parallel_bus_o[10], rx_special_flag_o,
      rx_parallel_bus_o[11]});
    next_word = {12'h000, 10'h0E5, 1'h1, 1'h0, 1'h0};
    rk(6);
    chk("ind_special", 12'h007, {9'h000, rx_parallel_bus_o[10], rx_special_flag_o, rx_parallel_bus_o[11]});
    n_store = 0;
    send(10'h01C, 1'h1);
    chk("irq_set", 12'h001, {11'h000, rx_parallel_bus_o[8]});
    send(10'h07C, 1'h1);
    chk("irq_clear", 12'h000, {11'h000, rx_parallel_bus_o[8]});
    send(10'h055, 1'h0);
    chk("stores_policy1", 12'h001, 12'(n_store));
    chk("store_word", 12'h055, {2'h0, st_word.dec});
    rx_discard_policy = 2'h0;
    rk(4);
    send(10'h07C, 1'h1);
    chk("stores_policy0", 12'h002, 12'(n_store));
    chk("store_cmd", 12'h07C, {2'h0, st_word.dec});
    rx_discard_policy = 2'h1;
    rk(4);
    send(10'h01C, 1'h1);
    $display("test rx_decoded done");
    // fifo bypassed, decoder on: violation shown, interrupt bit dead
    fifo_bypass_n = 1'h0;
    rx_dec_char = {12'h000, 10'h0AB, 1'h0, 1'h1, 1'h0};
    rx_dec_valid = 1'h1;
    rk(6);
    chk("bus_bypass_dec", 12'h4AB, {1'h0, rx_parallel_bus_o[10:0]});
    rx_dec_valid = 1'h0;
    $display("test rx_bypass done");
    end_sim;
  end
endmodule
